// ### inc/dcc_consts.vh
// Constants for the device control command decoder
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
`define DCC_MASK_UNICAST   3'h0
`define DCC_MASK_MULTICAST 3'h3
`define DCC_MASK_BROADCAST 3'h7
`define DCC_MASK_MSB       7
`define DCC_MASK_LSB       5
`define DCC_OFFSET_MSB     4
`define DCC_OFFSET_LSB     3
`define DCC_BURST_MSB      2
`define DCC_BURST_LSB      1
`define DCC_REGMODE_BIT    0
`define DCC_ADDR_MSB       7
`define DCC_ADDR_LSB       1
`define DCC_GROUP_MSB      7
`define DCC_GROUP_LSB      4
`define DCC_CKEN_BIT       7
`define DCC_PARDIS_BIT     6
`define DCC_GCLR_BIT       3
`define DCC_RESET_CKEN     1'b0
`define DCC_RESET_PARDIS   1'b0
`endif

// ### rtl/dcc_match.v
// Address mask match for the device control command
`include "dcc_consts.vh"
`default_nettype none
module dcc_match (
  // Command fields
  input  wire [2:0] mask,
  input  wire [6:0] target,
  // Own serial address
  input  wire [6:0] own_addr,
  // Result
  output reg        hit
);
  always @* begin
    case (mask)
      `DCC_MASK_UNICAST:   hit = (target == own_addr);
      `DCC_MASK_MULTICAST: hit = (target[6:3] == own_addr[6:3]);
      `DCC_MASK_BROADCAST: hit = 1'b1;
      default:             hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/dcc_decoder.v
// Device control command decoder, byte-level front end
//
// Summary of operation
// - Refuse the command after a parity or checksum error when opened by repeated start.
// - Mask 000 acts only when all seven target address bits equal own address.
// - Mask 011 compares upper four target bits against the upper four own address bits.
// - Mask 111 ignores target address and always acts.
// - Generic mode start offset chooses which data byte arrives first.
// - Generic mode with checksum: burst length 1 to 4 bytes, then checksum byte.
// - Register mode bit 0 means generic payload layout.
// - Register mode bit 1 means register access bytes, format per checksum enable.
// - Data byte 0 bit 7 writes the checksum enable bit.
// - Data byte 0 bit 6 writes the parity disable bit.
// - Data byte 1 bit 3 set clears all events and pending interrupt.
`include "dcc_consts.vh"
`default_nettype none
module dcc_decoder (
  // Clock and reset
  input  wire       CLK,
  input  wire       RESET_N,
  // Received byte stream from the bus layer
  input  wire       CMD_START,
  input  wire       CMD_REPEATED,
  input  wire       BYTE_VALID,
  input  wire [7:0] BYTE_DATA,
  input  wire       FRAME_END,
  // Prior transaction status
  input  wire       PRIOR_ERROR,
  // Own serial address
  input  wire [6:0] OWN_ADDR,
  // Acknowledge decision and configuration
  output reg        CMD_NACK,
  output reg        CHECKSUM_ENABLE,
  output reg        PARITY_DISABLE,
  output reg        GLOBAL_CLEAR,
  // Register access handoff
  output reg        REG_ACCESS,
  output reg        REG_BYTE_VALID,
  output reg  [7:0] REG_BYTE,
  output reg        REG_CHECKED,
  // Checksum position marker
  output reg        CHECKSUM_BYTE
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  // One flip-flop per state keeps the decode shallow
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_MODE = 5'h02;
  localparam [4:0] ST_ADDR = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  // ----------------------------------------
  // Frame registers
  // ----------------------------------------
  // State and fields of the mode byte
  reg  [4:0] state;
  reg  [2:0] mask;
  reg  [1:0] offset;
  reg  [1:0] burst;
  reg        regmode;
  // Data byte position and frozen checksum setting
  reg  [1:0] index;
  reg  [2:0] count;
  reg        sum_on;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  reg  [4:0] next_state;
  reg  [2:0] next_mask;
  reg  [1:0] next_offset;
  reg  [1:0] next_burst;
  reg        next_regmode;
  reg  [1:0] next_index;
  reg  [2:0] next_count;
  reg        next_sum_on;
  // Output values
  reg        next_cmd_nack;
  reg        next_checksum_enable;
  reg        next_parity_disable;
  reg        next_global_clear;
  reg        next_reg_access;
  reg        next_reg_byte_valid;
  reg  [7:0] next_reg_byte;
  reg        next_reg_checked;
  reg        next_checksum_byte;

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  wire [2:0] mode_mask;
  wire [1:0] mode_offset;
  wire [1:0] mode_burst;
  wire       mode_regmode;
  wire [6:0] addr_target;
  wire       data_cken;
  wire       data_pardis;
  wire       data_gclr;

  assign mode_mask    = BYTE_DATA[`DCC_MASK_MSB:`DCC_MASK_LSB];
  assign mode_offset  = BYTE_DATA[`DCC_OFFSET_MSB:`DCC_OFFSET_LSB];
  assign mode_burst   = BYTE_DATA[`DCC_BURST_MSB:`DCC_BURST_LSB];
  assign mode_regmode = BYTE_DATA[`DCC_REGMODE_BIT];
  assign addr_target  = BYTE_DATA[`DCC_ADDR_MSB:`DCC_ADDR_LSB];
  // Only three payload bits carry meaning, the rest are reserved
  assign data_cken    = BYTE_DATA[`DCC_CKEN_BIT];
  assign data_pardis  = BYTE_DATA[`DCC_PARDIS_BIT];
  assign data_gclr    = BYTE_DATA[`DCC_GCLR_BIT];

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  wire       hit;
  wire       refuse;
  wire [2:0] sum_pos;
  wire       sum_due;
  wire       in_burst;
  wire       lands_cfg;
  wire       lands_clr;
  wire [1:0] next_slot;
  wire [2:0] next_seen;

  // Refusal only applies to a frame opened by repeated start
  assign refuse    = CMD_REPEATED & PRIOR_ERROR;
  // Burst code 0 to 3 stands for 1 to 4 data bytes
  assign sum_pos   = {1'b0, burst} + 3'h1;
  assign sum_due   = sum_on & (count == sum_pos);
  // Bytes past the fourth are dropped rather than wrapping twice
  assign in_burst  = (count < 3'h4);

  // Data index walks modulo four from the start offset
  assign next_slot = index + 2'h1;
  assign next_seen = count + 3'h1;
  assign lands_cfg = (index == 2'h0);
  assign lands_clr = (index == 2'h1);

  // ----------------------------------------
  // Address match
  // ----------------------------------------
  dcc_match u_match (
    .mask     (mask),
    .target   (addr_target),
    .own_addr (OWN_ADDR),
    .hit      (hit)
  );

  // ----------------------------------------
  // Next state and outputs
  // ----------------------------------------
  always @* begin
    // Levels keep their value unless a start, a frame end or a byte rewrites them
    next_state           = state;
    next_mask            = mask;
    next_offset          = offset;
    next_burst           = burst;
    next_regmode         = regmode;
    next_index           = index;
    next_count           = count;
    next_sum_on          = sum_on;
    next_cmd_nack        = CMD_NACK;
    next_checksum_enable = CHECKSUM_ENABLE;
    next_parity_disable  = PARITY_DISABLE;
    next_reg_access      = REG_ACCESS;
    next_reg_byte        = REG_BYTE;
    next_reg_checked     = REG_CHECKED;
    // Pulses fall back after one cycle
    next_global_clear    = 1'b0;
    next_reg_byte_valid  = 1'b0;
    next_checksum_byte   = 1'b0;

    if (CMD_START) begin
      // Repeated start after an error is refused outright
      next_cmd_nack   = refuse;
      next_reg_access = 1'b0;
      next_state      = refuse ? ST_SKIP : ST_MODE;
    end else if (FRAME_END) begin
      next_state      = ST_IDLE;
      next_reg_access = 1'b0;
    end else if (BYTE_VALID) begin
      case (state)
        ST_MODE: begin
          next_mask    = mode_mask;
          next_offset  = mode_offset;
          next_burst   = mode_burst;
          next_regmode = mode_regmode;
          next_state   = ST_ADDR;
        end

        ST_ADDR: begin
          next_index       = offset;
          next_count       = 3'h0;
          // Checksum setting frozen here, so an enable bit written by
          // this frame's own data cannot move this frame's checksum
          next_sum_on      = CHECKSUM_ENABLE & ~regmode;
          next_reg_access  = hit & regmode;
          next_reg_checked = CHECKSUM_ENABLE;
          next_state       = hit ? ST_DATA : ST_SKIP;
        end

        ST_DATA: begin
          if (regmode) begin
            next_reg_byte_valid = 1'b1;
            next_reg_byte       = BYTE_DATA;
          end else if (sum_due) begin
            // Checksum trails the burst; later bytes are ignored
            next_checksum_byte = 1'b1;
            next_state         = ST_SKIP;
          end else if (in_burst) begin
            // Generic layout
            if (lands_cfg) begin
              next_checksum_enable = data_cken;
              next_parity_disable  = data_pardis;
            end
            if (lands_clr) begin
              next_global_clear = data_gclr;
            end
            next_index = next_slot;
            next_count = next_seen;
          end
        end

        ST_IDLE: begin
          // Stray bytes outside a frame are dropped
          next_state = ST_IDLE;
        end

        ST_SKIP: begin
          // Refused or unmatched frames wait here for the frame end
          next_state = ST_SKIP;
        end

        default: begin
          // An illegal code falls back to idle
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frame register update
  // ----------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= ST_IDLE;
      mask    <= 3'h0;
      offset  <= 2'h0;
      burst   <= 2'h0;
      regmode <= 1'b0;
      index   <= 2'h0;
      count   <= 3'h0;
      sum_on  <= 1'b0;
    end else begin
      state   <= next_state;
      mask    <= next_mask;
      offset  <= next_offset;
      burst   <= next_burst;
      regmode <= next_regmode;
      index   <= next_index;
      count   <= next_count;
      sum_on  <= next_sum_on;
    end
  end

  // ----------------------------------------
  // Level output update
  // ----------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CMD_NACK        <= 1'b0;
      CHECKSUM_ENABLE <= `DCC_RESET_CKEN;
      PARITY_DISABLE  <= `DCC_RESET_PARDIS;
      REG_ACCESS      <= 1'b0;
      REG_BYTE        <= 8'h00;
      REG_CHECKED     <= 1'b0;
    end else begin
      CMD_NACK        <= next_cmd_nack;
      CHECKSUM_ENABLE <= next_checksum_enable;
      PARITY_DISABLE  <= next_parity_disable;
      REG_ACCESS      <= next_reg_access;
      REG_BYTE        <= next_reg_byte;
      REG_CHECKED     <= next_reg_checked;
    end
  end

  // ----------------------------------------
  // Pulse output update
  // ----------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GLOBAL_CLEAR   <= 1'b0;
      REG_BYTE_VALID <= 1'b0;
      CHECKSUM_BYTE  <= 1'b0;
    end else begin
      GLOBAL_CLEAR   <= next_global_clear;
      REG_BYTE_VALID <= next_reg_byte_valid;
      CHECKSUM_BYTE  <= next_checksum_byte;
    end
  end
endmodule
`default_nettype wire

// ### sim/dcc_decoder_properties.sv
// Property checker for the device control command decoder
`default_nettype none
module dcc_decoder_properties (
  // Clock, reset and frame stream
  input wire logic       CLK, RESET_N, CMD_START, CMD_REPEATED, BYTE_VALID, PRIOR_ERROR,
  input wire logic [7:0] BYTE_DATA, REG_BYTE,
  // Decisions and configuration
  input wire logic       CMD_NACK, CHECKSUM_ENABLE, PARITY_DISABLE, GLOBAL_CLEAR,
  input wire logic       REG_ACCESS, REG_BYTE_VALID, CHECKSUM_BYTE
);
  timeunit 1ns / 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_nack_set: assert property (CMD_START && CMD_REPEATED && PRIOR_ERROR |=> CMD_NACK)
    else $error("refusal missing");
  a_nack_hold: assert property (CMD_NACK && !CMD_START |=> CMD_NACK)
    else $error("refusal dropped");
  a_nack_quiet: assert property (CMD_NACK |-> !GLOBAL_CLEAR && !REG_BYTE_VALID)
    else $error("refused command acted");
  a_cken_cause: assert property ($changed(CHECKSUM_ENABLE) |->
    $past(BYTE_VALID) && CHECKSUM_ENABLE == $past(BYTE_DATA[7])) else $error("bad enable");
  a_pdis_cause: assert property ($changed(PARITY_DISABLE) |->
    $past(BYTE_VALID) && PARITY_DISABLE == $past(BYTE_DATA[6])) else $error("bad parity");
  a_clear_cause: assert property (GLOBAL_CLEAR |->
    $past(BYTE_VALID) && $past(BYTE_DATA[3])) else $error("clear without its bit");
  a_reg_pass: assert property (REG_BYTE_VALID |->
    REG_ACCESS && REG_BYTE == $past(BYTE_DATA)) else $error("register byte wrong");
  a_sum_cause: assert property (CHECKSUM_BYTE |->
    $past(BYTE_VALID) && !$past(CMD_START)) else $error("checksum mark without byte");
  c_refused: cover property (CMD_NACK);
  c_clear: cover property (GLOBAL_CLEAR);
  c_reg: cover property (REG_BYTE_VALID);
endmodule
bind dcc_decoder dcc_decoder_properties u_dcc_decoder_properties (.*);
`default_nettype wire

// ### sim/dcc_host.sv
// Host model driving device control frames into the decoder
`default_nettype none
module dcc_host (
  input  wire logic       CLK,
  output var  logic       CMD_START, CMD_REPEATED, BYTE_VALID, FRAME_END,
  output var  logic [7:0] BYTE_DATA
);
  timeunit 1ns / 1ps;
  initial {CMD_START, CMD_REPEATED, BYTE_VALID, FRAME_END, BYTE_DATA} = 12'h000;
  task automatic frame(input logic rep, input logic [7:0] b[$]);
    @(posedge CLK) {CMD_START, CMD_REPEATED} <= {1'b1, rep};
    foreach (b[i])
      @(posedge CLK) {CMD_START, BYTE_VALID, BYTE_DATA} <= {2'h1, b[i]};
    // Released data inverts, never holds its last value
    @(posedge CLK) {BYTE_VALID, FRAME_END, BYTE_DATA} <= {2'h1, ~BYTE_DATA};
    @(posedge CLK) FRAME_END <= 1'b0;
    // Idle edge lets pulse counters settle before the caller looks
    @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ### sim/dcc_decoder_test.sv
// Self-checking bench for the device control command decoder
`default_nettype none
module dcc_decoder_test;
  timeunit 1ns / 1ps;
  logic       CLK = 1'b0, RESET_N = 1'b0, PRIOR_ERROR = 1'b0, got = 1'b0, had_sum;
  logic       CMD_START, CMD_REPEATED, BYTE_VALID, FRAME_END, CMD_NACK, REG_ACCESS;
  logic       CHECKSUM_ENABLE, PARITY_DISABLE, GLOBAL_CLEAR, REG_BYTE_VALID;
  logic       REG_CHECKED, CHECKSUM_BYTE, had_acc;
  logic [7:0] BYTE_DATA, REG_BYTE, first_reg, n_clr = 8'h00, n_sum = 8'h00;
  int         fail_count = 0, total_checks = 0, cyc = 0;
  always #10 CLK = ~CLK;
  dcc_host u_dcc_host (.*);
  dcc_decoder u_dcc_decoder (.*, .OWN_ADDR(7'h35));
  // Pulses are counted as they pass, before the frame task returns
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    n_clr <= n_clr + {7'h00, GLOBAL_CLEAR === 1'b1};
    n_sum <= n_sum + {7'h00, CHECKSUM_BYTE === 1'b1};
    if (REG_BYTE_VALID === 1'b1 && !got)
      {got, first_reg, had_sum, had_acc} <= {1'b1, REG_BYTE, REG_CHECKED, REG_ACCESS};
    if (cyc == 2000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    u_dcc_host.frame(1'b0, '{8'he0, 8'h00, 8'hc0, 8'h08});
    chk(CHECKSUM_ENABLE, 8'h01);
    chk(PARITY_DISABLE, 8'h01);
    chk(n_clr, 8'h01);
    u_dcc_host.frame(1'b0, '{8'h00, 8'h6c, 8'h00});
    chk(CHECKSUM_ENABLE, 8'h01);
    u_dcc_host.frame(1'b0, '{8'h00, 8'h6a, 8'h3f, 8'h5b});
    chk(CHECKSUM_ENABLE, 8'h00);
    chk(PARITY_DISABLE, 8'h00);
    chk(n_sum, 8'h01);
    // Offset 1: first data byte lands on index 1
    u_dcc_host.frame(1'b0, '{8'h68, 8'h64, 8'hf7, 8'hff, 8'hff, 8'h80});
    chk(CHECKSUM_ENABLE, 8'h01);
    chk(PARITY_DISABLE, 8'h00);
    chk(n_clr, 8'h01);
    u_dcc_host.frame(1'b0, '{8'h60, 8'hea, 8'h00, 8'h00});
    chk(CHECKSUM_ENABLE, 8'h01);
    // Three-byte register write; only the first byte and its flags are checked
    u_dcc_host.frame(1'b0, '{8'h01, 8'h6a, 8'h12, 8'h00, 8'h77});
    chk(first_reg, 8'h12);
    chk(had_sum, 8'h01);
    chk(had_acc, 8'h01);
    chk(REG_ACCESS, 8'h00);
    chk(CHECKSUM_ENABLE, 8'h01);
    PRIOR_ERROR <= 1'b1;
    u_dcc_host.frame(1'b1, '{8'he0, 8'h00, 8'h00, 8'h00});
    chk(CMD_NACK, 8'h01);
    chk(CHECKSUM_ENABLE, 8'h01);
    u_dcc_host.frame(1'b0, '{8'he0, 8'h00, 8'h00, 8'h00});
    chk(CMD_NACK, 8'h00);
    chk(CHECKSUM_ENABLE, 8'h00);
    // Mask 001 is no legal selection, so a matching address is ignored
    u_dcc_host.frame(1'b0, '{8'h20, 8'h6a, 8'h80});
    chk(CHECKSUM_ENABLE, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
